// ---- inc/cpms_map.vh ----
`ifndef CPMS_MAP_VH
`define CPMS_MAP_VH
// register word indices, byte address is index times four
`define CPMS_IDX_MODE     10'h0db
`define CPMS_IDX_EXEC_LO  10'h10a
`define CPMS_IDX_EXEC_HI  10'h10b
`define CPMS_IDX_SVC_CYC  10'h10c
`define CPMS_IDX_STATUS   10'h110
`define CPMS_IDX_MASK     10'h111
`define CPMS_IDX_CTRL     10'h112
`define CPMS_IDX_SVC_TIME 10'h113
`define CPMS_IDX_MIN_CYC  10'h114
// mode field inside the setup word
`define CPMS_MODE_MSB     15
`define CPMS_MODE_LSB     8
`define CPMS_SETUP_RST    16'h0000
// mode codes
`define CPMS_MODE_NORMAL  8'h00
`define CPMS_MODE_SYNC    8'h01
`define CPMS_MODE_ASYNC   8'h02
`define CPMS_MODE_BAD_A   8'h03
`define CPMS_MODE_BAD_B   8'h04
`define CPMS_MODE_PRIO    8'h05
// status and control bits
`define CPMS_ST_SETUP     0
`define CPMS_ST_OVR       1
`define CPMS_ST_CYC       2
`define CPMS_ST_W         3
`define CPMS_CTL_CLR      0
// timing
`define CPMS_CLK_NS       40
`define CPMS_TICK_NS      100000
`define CPMS_MS_NS        1000000
`define CPMS_TICK_CYC     (`CPMS_TICK_NS / `CPMS_CLK_NS)
`define CPMS_MS_TICKS     (`CPMS_MS_NS / `CPMS_TICK_NS)
`define CPMS_OVR_MS       2000
`define CPMS_OVR_TICKS    (`CPMS_OVR_MS * `CPMS_MS_TICKS)
`define CPMS_PCT_DIV      25
`endif

// ---- design/cpms_div.v ----
`timescale 1ns/100ps
module cpms_div #(
  parameter integer DIV = 2500,
  parameter integer W   = 12
) (
  input  wire i_clock,
  input  wire i_sys_rst,
  input  wire i_en,
  output reg  o_tick
);
  localparam integer LAST_I = DIV - 1;
  localparam [W-1:0] LAST   = LAST_I[W-1:0];
  reg [W-1:0] cnt_q;

  // restarts from zero whenever disabled so ticks align to the start
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q  <= {W{1'b0}};
      o_tick <= 1'b0;
    end else if (!i_en) begin
      cnt_q  <= {W{1'b0}};
      o_tick <= 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_q  <= {W{1'b0}};
      o_tick <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 1'b1;
      o_tick <= 1'b0;
    end
  end
endmodule // cpms_div

// ---- design/cpms_irq.v ----
`timescale 1ns/100ps
module cpms_irq #(
  parameter integer W = 3
) (
  input  wire         i_clock,
  input  wire         i_sys_rst,
  input  wire [W-1:0] i_set,
  input  wire         i_clr_we,
  input  wire [W-1:0] i_clr_data,
  input  wire         i_mask_we,
  input  wire [W-1:0] i_mask_data,
  output wire [W-1:0] o_status,
  output reg  [W-1:0] o_mask,
  output reg          o_irq
);
  reg [W-1:0] status_q;
  genvar g;

  // a set in the clearing cycle wins
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      always @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst)
          status_q[g] <= 1'b0;
        else
          status_q[g] <= i_set[g] | (status_q[g] & ~(i_clr_we & i_clr_data[g]));
      end
    end
  endgenerate

  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_mask <= {W{1'b0}};
      o_irq  <= 1'b0;
    end else begin
      if (i_mask_we)
        o_mask <= i_mask_data;
      o_irq <= |(status_q & o_mask);
    end
  end

  assign o_status = status_q;
endmodule // cpms_irq

// ---- design/cpms_sched.v ----
`timescale 1ns/100ps
`include "cpms_map.vh"
module cpms_sched #(
  parameter integer TICK_CYC = `CPMS_TICK_CYC,
  parameter integer TICK_W   = 12
) (
  input  wire        i_clock,
  input  wire        i_sys_rst,
  input  wire        i_wb_cyc,
  input  wire        i_wb_stb,
  input  wire        i_wb_we,
  input  wire [11:0] i_wb_adr,
  input  wire [3:0]  i_wb_sel,
  input  wire [31:0] i_wb_dat,
  output reg  [31:0] o_wb_dat,
  output reg         o_wb_ack,
  input  wire        i_start,
  input  wire        i_run_mode,
  input  wire        i_prog_done,
  input  wire        i_refresh_done,
  input  wire        i_svc_cycle_end,
  input  wire        i_req_event,
  input  wire        i_req_port,
  input  wire        i_req_dlink,
  output wire        o_prog_en,
  output wire        o_refresh_en,
  output wire        o_svc_grant,
  output wire        o_svc_mem_en,
  output wire        o_dlink_en,
  output wire        o_fatal_halt,
  output reg         o_setup_error,
  output reg         o_servicing_overrun_flag,
  output wire        o_irq
);
  localparam [6:0] S_IDLE  = 7'h01;
  localparam [6:0] S_EXEC  = 7'h02;
  localparam [6:0] S_SLICE = 7'h04;
  localparam [6:0] S_REFR  = 7'h08;
  localparam [6:0] S_SVC   = 7'h10;
  localparam [6:0] S_WAIT  = 7'h20;
  localparam [6:0] S_HALT  = 7'h40;

  localparam [31:0] MS_W = `CPMS_MS_TICKS, OVR_W = `CPMS_OVR_TICKS, PCT_W = `CPMS_PCT_DIV - 1;
  localparam [15:0] MS_TICKS  = MS_W[15:0];
  localparam [15:0] OVR_TICKS = OVR_W[15:0];
  localparam [4:0]  PCT_LAST  = PCT_W[4:0];

  function is_par;
    input [7:0] code;
    begin
      is_par = (code == `CPMS_MODE_SYNC) || (code == `CPMS_MODE_ASYNC);
    end
  endfunction

  function is_prio;
    input [7:0] code;
    begin
      is_prio = (code >= `CPMS_MODE_PRIO);
    end
  endfunction

  function [15:0] merge16;
    input [15:0] old;
    input [15:0] nw;
    input [1:0]  sel;
    begin
      merge16 = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  // registers
  reg  [15:0] setup_q;
  reg  [15:0] svc_time_q;
  reg  [15:0] min_cyc_q;
  reg  [31:0] exec_word_q;
  reg  [15:0] svc_word_q;
  reg  [7:0]  mode_q;
  reg  [6:0]  state_q;
  reg  [6:0]  state_d;
  reg  [31:0] exec_acc_q;
  reg  [15:0] cyc_q;
  reg  [15:0] slice_q;
  reg  [15:0] svc_cnt_q;
  reg  [4:0]  pct_sub_q;
  reg  [15:0] pct_acc_q;
  reg  [15:0] budget_q;
  reg         svc_win;
  reg         mem_win;
  reg         exec_cnt;

  wire        tick;
  wire        running;
  wire        par_mode;
  wire        prio_mode;
  wire        async_mode;
  wire        sync_mode;
  wire [7:0]  code_in;
  wire        bad_code;
  wire [15:0] svc_len;
  wire [15:0] slice_len;
  wire        slice_end;
  wire        svc_end;
  wire        wait_done;
  wire        cyc_end;
  wire        ovr_evt;
  wire        start_ok;
  wire        wb_req;
  wire        wb_wr;
  wire [9:0]  wb_idx;
  wire        clr_wr;
  wire [`CPMS_ST_W-1:0] irq_set;
  wire [`CPMS_ST_W-1:0] irq_status;
  wire [`CPMS_ST_W-1:0] irq_mask;

  assign running    = !(state_q == S_IDLE) && !(state_q == S_HALT);
  assign par_mode   = is_par(mode_q);
  assign prio_mode  = is_prio(mode_q);
  assign async_mode = (mode_q == `CPMS_MODE_ASYNC);
  assign sync_mode  = (mode_q == `CPMS_MODE_SYNC);
  assign code_in    = setup_q[`CPMS_MODE_MSB:`CPMS_MODE_LSB];
  assign bad_code   = (code_in == `CPMS_MODE_BAD_A) || (code_in == `CPMS_MODE_BAD_B);
  assign start_ok   = i_start && i_run_mode;

  // user time wins; zero falls back to 4% of the previous cycle
  assign svc_len   = (svc_time_q != 16'h0000) ? svc_time_q : budget_q;
  assign slice_len = {8'h00, mode_q} * MS_TICKS;
  assign slice_end = tick && (slice_q + 16'h0001 >= slice_len);
  assign svc_end   = tick && (slice_q + 16'h0001 >= svc_len);
  assign wait_done = (cyc_q >= min_cyc_q);
  assign cyc_end   = (state_q == S_WAIT) && wait_done;
  // past 2 s of servicing cycle in a parallel mode
  assign ovr_evt   = running && par_mode && tick && (svc_cnt_q >= OVR_TICKS);

  cpms_div #(
    .DIV (TICK_CYC),
    .W   (TICK_W)
  ) u_div (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_en      (running),
    .o_tick    (tick)
  );

  // state machine
  always @* begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (start_ok)
          state_d = S_EXEC;
      end
      S_EXEC: begin
        if (i_prog_done)
          state_d = S_REFR;
        else if (prio_mode && slice_end)
          state_d = S_SLICE;
      end
      S_SLICE: begin
        if (svc_end)
          state_d = S_EXEC;
      end
      S_REFR: begin
        // async skips the memory window, which is what makes sync longer
        if (i_refresh_done)
          state_d = async_mode ? S_WAIT : S_SVC;
      end
      S_SVC: begin
        if (svc_end)
          state_d = S_WAIT;
      end
      S_WAIT: begin
        if (wait_done)
          state_d = S_EXEC;
      end
      S_HALT: begin
        if (start_ok)
          state_d = S_EXEC;
      end
      default: state_d = S_IDLE;
    endcase
    if (ovr_evt)
      state_d = S_HALT;
    else if (running && !i_run_mode)
      state_d = S_IDLE;
    else if (i_start)
      state_d = i_run_mode ? S_EXEC : S_IDLE;
  end

  // servicing windows per mode
  always @* begin
    svc_win  = 1'b0;
    mem_win  = 1'b0;
    exec_cnt = 1'b0;
    if (running) begin
      if (async_mode) begin
        svc_win = 1'b1;
        mem_win = 1'b1;
      end else if (sync_mode) begin
        svc_win = 1'b1;
        mem_win = (state_q == S_SVC);
      end else if (prio_mode) begin
        svc_win = (state_q == S_SLICE) || (state_q == S_SVC);
        mem_win = svc_win;
      end else begin
        svc_win = (state_q == S_SVC);
        mem_win = svc_win;
      end
      if (mode_q == `CPMS_MODE_NORMAL)
        exec_cnt = (state_q == S_EXEC);
      else
        exec_cnt = (state_q == S_EXEC) || (state_q == S_SLICE) || (par_mode && svc_win);
    end
  end

  // only unit events and port traffic are servicing; data links ride the refresh
  assign o_svc_grant  = svc_win && (i_req_event || i_req_port);
  assign o_svc_mem_en = mem_win;
  assign o_dlink_en   = (state_q == S_REFR) && i_req_dlink;
  assign o_prog_en    = (state_q == S_EXEC);
  assign o_refresh_en = (state_q == S_REFR);
  assign o_fatal_halt = (state_q == S_HALT);

  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= S_IDLE;
      mode_q  <= `CPMS_MODE_NORMAL;
    end else begin
      state_q <= state_d;
      if (i_start)
        mode_q <= bad_code ? `CPMS_MODE_NORMAL : code_in;
    end
  end

  // timing counters, all in 0.1 ms ticks
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      exec_acc_q  <= 32'h0000_0000;
      exec_word_q <= 32'h0000_0000;
      cyc_q       <= 16'h0000;
      slice_q     <= 16'h0000;
      pct_sub_q   <= 5'h00;
      pct_acc_q   <= 16'h0000;
      budget_q    <= 16'h0001;
    end else if (i_start) begin
      exec_acc_q  <= 32'h0000_0000;
      exec_word_q <= 32'h0000_0000;
      cyc_q       <= 16'h0000;
      slice_q     <= 16'h0000;
      pct_sub_q   <= 5'h00;
      pct_acc_q   <= 16'h0000;
    end else if (cyc_end) begin
      exec_word_q <= exec_acc_q;
      exec_acc_q  <= 32'h0000_0000;
      cyc_q       <= 16'h0000;
      slice_q     <= 16'h0000;
      pct_sub_q   <= 5'h00;
      pct_acc_q   <= 16'h0000;
      budget_q    <= (pct_acc_q == 16'h0000) ? 16'h0001 : pct_acc_q;
    end else begin
      if (tick && exec_cnt)
        exec_acc_q <= exec_acc_q + 32'h0000_0001;
      if (tick && running && (cyc_q != 16'hffff))
        cyc_q <= cyc_q + 16'h0001;
      // one budget tick per 25 cycle ticks gives 4% exactly
      if (tick && running) begin
        if (pct_sub_q == PCT_LAST) begin
          pct_sub_q <= 5'h00;
          pct_acc_q <= pct_acc_q + 16'h0001;
        end else begin
          pct_sub_q <= pct_sub_q + 5'h01;
        end
      end
      if (state_q != state_d)
        slice_q <= 16'h0000;
      else if (tick)
        slice_q <= slice_q + 16'h0001;
    end
  end

  // servicing cycle time, only meaningful in parallel modes
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      svc_cnt_q  <= 16'h0000;
      svc_word_q <= 16'h0000;
    end else if (i_start) begin
      svc_cnt_q  <= 16'h0000;
      svc_word_q <= 16'h0000;
    end else if (running && par_mode && i_run_mode) begin
      if (i_svc_cycle_end) begin
        svc_word_q <= svc_cnt_q + {15'h0000, tick};
        svc_cnt_q  <= 16'h0000;
      end else if (tick) begin
        svc_cnt_q <= svc_cnt_q + 16'h0001;
      end
    end
  end

  // bus slave, one wait state then ack
  assign wb_req = i_wb_cyc && i_wb_stb;
  assign wb_wr  = wb_req && i_wb_we && o_wb_ack;
  assign wb_idx = i_wb_adr[11:2];
  assign clr_wr = wb_wr && (wb_idx == `CPMS_IDX_CTRL) && i_wb_sel[0] && i_wb_dat[`CPMS_CTL_CLR];

  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wb_ack   <= 1'b0;
      o_wb_dat   <= 32'h0000_0000;
      setup_q    <= `CPMS_SETUP_RST;
      svc_time_q <= 16'h0000;
      min_cyc_q  <= 16'h0000;
    end else begin
      o_wb_ack <= wb_req && !o_wb_ack;
      if (wb_req && !o_wb_ack) begin
        case (wb_idx)
          `CPMS_IDX_MODE:     o_wb_dat <= {16'h0000, setup_q};
          `CPMS_IDX_EXEC_LO:  o_wb_dat <= {16'h0000, exec_word_q[15:0]};
          `CPMS_IDX_EXEC_HI:  o_wb_dat <= {16'h0000, exec_word_q[31:16]};
          `CPMS_IDX_SVC_CYC:  o_wb_dat <= {16'h0000, svc_word_q};
          `CPMS_IDX_STATUS:   o_wb_dat <= {29'h0000_0000, irq_status};
          `CPMS_IDX_MASK:     o_wb_dat <= {29'h0000_0000, irq_mask};
          `CPMS_IDX_SVC_TIME: o_wb_dat <= {16'h0000, svc_time_q};
          `CPMS_IDX_MIN_CYC:  o_wb_dat <= {16'h0000, min_cyc_q};
          default:            o_wb_dat <= 32'h0000_0000;
        endcase
      end
      if (wb_wr) begin
        case (wb_idx)
          `CPMS_IDX_MODE:     setup_q    <= merge16(setup_q, i_wb_dat[15:0], i_wb_sel[1:0]);
          `CPMS_IDX_SVC_TIME: svc_time_q <= merge16(svc_time_q, i_wb_dat[15:0], i_wb_sel[1:0]);
          `CPMS_IDX_MIN_CYC:  min_cyc_q  <= merge16(min_cyc_q, i_wb_dat[15:0], i_wb_sel[1:0]);
          default:            setup_q    <= setup_q;
        endcase
      end
    end
  end

  // error flags: a new event wins over a clear
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_setup_error            <= 1'b0;
      o_servicing_overrun_flag <= 1'b0;
    end else begin
      if (i_start && bad_code)
        o_setup_error <= 1'b1;
      else if (i_start || clr_wr)
        o_setup_error <= 1'b0;
      if (ovr_evt)
        o_servicing_overrun_flag <= 1'b1;
      else if (i_start || clr_wr)
        o_servicing_overrun_flag <= 1'b0;
    end
  end

  assign irq_set[`CPMS_ST_SETUP] = i_start && bad_code;
  assign irq_set[`CPMS_ST_OVR]   = ovr_evt;
  assign irq_set[`CPMS_ST_CYC]   = cyc_end;

  cpms_irq #(
    .W (`CPMS_ST_W)
  ) u_irq (
    .i_clock     (i_clock),
    .i_sys_rst   (i_sys_rst),
    .i_set       (irq_set),
    .i_clr_we    (wb_wr && (wb_idx == `CPMS_IDX_STATUS) && i_wb_sel[0]),
    .i_clr_data  (i_wb_dat[`CPMS_ST_W-1:0]),
    .i_mask_we   (wb_wr && (wb_idx == `CPMS_IDX_MASK) && i_wb_sel[0]),
    .i_mask_data (i_wb_dat[`CPMS_ST_W-1:0]),
    .o_status    (irq_status),
    .o_mask      (irq_mask),
    .o_irq       (o_irq)
  );
endmodule // cpms_sched

// ---- verif/cpms_periph.sv ----
`timescale 1ns/100ps
// peripheral units and ports: requests servicing and ends a servicing cycle every i_period clocks
module cpms_periph (
  input  wire        i_clock,
  input  wire        i_sys_rst,
  input  wire        i_stall,
  input  wire [7:0]  i_period,
  output logic       o_req_event,
  output logic       o_req_port,
  output logic       o_req_dlink,
  output logic       o_cycle_end
);
  logic [7:0] cnt_q;
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q <= 8'h00;
      o_req_event <= 1'b0;
      o_req_port <= 1'b0;
      o_req_dlink <= 1'b0;
      o_cycle_end <= 1'b0;
    end else begin
      // a stalled unit stops its event and port requests, so grants must fall silent too
      o_req_event <= ~i_stall;
      o_req_dlink <= 1'b1;
      o_cycle_end <= 1'b0;
      if (i_stall) begin
        cnt_q <= 8'h00;
        o_req_port <= 1'b0;
      end else if (cnt_q == i_period - 8'h01) begin
        cnt_q <= 8'h00;
        o_cycle_end <= 1'b1;
        o_req_port <= ~o_req_port;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule // cpms_periph

// ---- verif/cpms_sched_monitor.sv ----
`timescale 1ns/100ps
`include "cpms_map.vh"
module cpms_sched_monitor (
  input wire        i_clock,
  input wire        i_sys_rst,
  input wire        i_wb_cyc,
  input wire        i_wb_stb,
  input wire        i_wb_we,
  input wire [11:0] i_wb_adr,
  input wire [3:0]  i_wb_sel,
  input wire [31:0] i_wb_dat,
  input wire        o_wb_ack,
  input wire        i_start,
  input wire        i_run_mode,
  input wire        i_req_event,
  input wire        i_req_port,
  input wire        i_req_dlink,
  input wire        o_prog_en,
  input wire        o_refresh_en,
  input wire        o_svc_grant,
  input wire        o_svc_mem_en,
  input wire        o_dlink_en,
  input wire        o_fatal_halt,
  input wire        o_setup_error,
  input wire        o_servicing_overrun_flag
);
  logic [7:0] pend_q;
  logic [7:0] mode_q;
  wire wr = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack;
  wire wr_mode = wr && i_wb_adr[11:2] == `CPMS_IDX_MODE && i_wb_sel[1];
  wire clr_wr = wr && i_wb_adr[11:2] == `CPMS_IDX_CTRL && i_wb_sel[0] && i_wb_dat[0];
  wire bad = pend_q == `CPMS_MODE_BAD_A || pend_q == `CPMS_MODE_BAD_B;
  wire req = i_req_event || i_req_port;
  // mirror of the setup word's mode field, taken into effect only at start
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pend_q <= 8'h00;
      mode_q <= 8'h00;
    end else begin
      if (wr_mode) pend_q <= i_wb_dat[15:8];
      if (i_start) mode_q <= pend_q;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  sequence halt_s;
    o_fatal_halt && !o_prog_en && !o_svc_grant;
  endsequence
  bus_answer_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
    else $error("bus answer not a single cycle ack");
  start_err_a: assert property (i_start |=> o_setup_error == $past(bad))
    else $error("setup error wrong after start");
  start_run_a: assert property (i_start && i_run_mode |=> o_prog_en)
    else $error("program not enabled after start");
  sync_defer_a: assert property (mode_q == `CPMS_MODE_SYNC |-> !(o_prog_en && o_svc_mem_en))
    else $error("memory servicing during execution in sync mode");
  sync_overlap_a: assert property (mode_q == `CPMS_MODE_SYNC && o_prog_en && req |-> o_svc_grant)
    else $error("sync mode did not overlap servicing");
  async_overlap_a: assert property (mode_q == `CPMS_MODE_ASYNC && o_prog_en && req |-> o_svc_grant && o_svc_mem_en)
    else $error("async mode did not overlap memory servicing");
  serial_mode_a: assert property (mode_q != `CPMS_MODE_SYNC && mode_q != `CPMS_MODE_ASYNC |-> !(o_prog_en && o_svc_grant))
    else $error("servicing overlapped execution in serial mode");
  dlink_excl_a: assert property (o_dlink_en |-> o_refresh_en && i_req_dlink)
    else $error("data link outside refresh");
  no_req_a: assert property (!req |-> !o_svc_grant)
    else $error("grant without event or port request");
  overrun_halt_a: assert property ($rose(o_servicing_overrun_flag) |-> ##[0:1] halt_s ##1 halt_s)
    else $error("overrun did not halt");
  overrun_hold_a: assert property (o_servicing_overrun_flag && !i_start && !clr_wr |=> o_servicing_overrun_flag)
    else $error("overrun flag dropped early");
endmodule // cpms_sched_monitor
bind cpms_sched cpms_sched_monitor mon_u (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
  .o_wb_ack(o_wb_ack), .i_start(i_start), .i_run_mode(i_run_mode), .i_req_event(i_req_event),
  .i_req_port(i_req_port), .i_req_dlink(i_req_dlink), .o_prog_en(o_prog_en), .o_refresh_en(o_refresh_en),
  .o_svc_grant(o_svc_grant), .o_svc_mem_en(o_svc_mem_en), .o_dlink_en(o_dlink_en),
  .o_fatal_halt(o_fatal_halt), .o_setup_error(o_setup_error),
  .o_servicing_overrun_flag(o_servicing_overrun_flag));

// ---- verif/cpms_sched_tb.sv ----
`timescale 1ns/100ps
`include "cpms_map.vh"
module cpms_sched_tb;
  localparam int TK = 4;
  logic i_clock = 0, i_sys_rst = 1, cyc = 0, stb = 0, we = 0, start = 0, pdone = 0, rdone = 0, stall = 0, run = 1;
  logic [11:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] wdat = 0, r;
  logic [7:0] period = 8'd40;
  logic [7:0] codes [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'hff};
  wire [31:0] rdat;
  wire ack, ev, port, dl, cend, prog, refr, grant, mem, dlen, halt, serr, ovr, irq;
  int error_cnt = 0, tests_run = 0, seed = 32'ha31c44c0, n;
  typedef struct {string nm; logic [15:0] v; int tol;} cpms_exp_t;
  cpms_exp_t expq[$];
  cpms_exp_t e;
  always #20 i_clock = ~i_clock;
  cpms_sched #(.TICK_CYC(TK)) dut_u (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_start(start), .i_run_mode(run), .i_prog_done(pdone), .i_refresh_done(rdone), .i_svc_cycle_end(cend),
    .i_req_event(ev), .i_req_port(port), .i_req_dlink(dl), .o_prog_en(prog), .o_refresh_en(refr),
    .o_svc_grant(grant), .o_svc_mem_en(mem), .o_dlink_en(dlen), .o_fatal_halt(halt), .o_setup_error(serr),
    .o_servicing_overrun_flag(ovr), .o_irq(irq));
  cpms_periph peer_u (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_stall(stall), .i_period(period),
    .o_req_event(ev), .o_req_port(port), .o_req_dlink(dl), .o_cycle_end(cend));
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got, int tol = 0);
    tests_run++;
    if ((^got) === 1'bx || int'(got) + tol < int'(exp) || int'(got) > int'(exp) + tol) begin
      error_cnt++;
      $display("MISMATCH %s expected %h got %h", nm, exp, got);
    end
  endtask
  task automatic bus(logic w, logic [9:0] idx, logic [15:0] d);
    @(posedge i_clock);
    r = $random(seed);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'b0011;
    wdat <= {r[31:16], d};
    do @(posedge i_clock); while (ack !== 1'b1);
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask
  task automatic rd(logic [9:0] idx, string nm, logic [15:0] v, int tol = 0);
    expq.push_back('{nm, v, tol});
    bus(0, idx, 16'h0000);
  endtask
  task automatic go(logic [7:0] code);
    bus(1, `CPMS_IDX_MODE, {code, 8'h00});
    @(posedge i_clock);
    start <= 1;
    @(posedge i_clock);
    start <= 0;
    @(posedge i_clock);
  endtask
  task automatic run_cycle(int cycles);
    while (prog !== 1'b1) @(posedge i_clock);
    repeat (cycles) @(posedge i_clock);
    pdone <= 1;
    @(posedge i_clock);
    pdone <= 0;
    while (refr !== 1'b1) @(posedge i_clock);
    rdone <= 1;
    @(posedge i_clock);
    rdone <= 0;
    n = 0;
    while (prog !== 1'b1) begin
      @(posedge i_clock);
      n++;
    end
  endtask
  // read results are paired with the oldest note at the ack edge
  always @(posedge i_clock) begin
    if (ack === 1'b1 && cyc && !we && expq.size() > 0) begin
      e = expq.pop_front();
      chk(e.nm, e.v, rdat[15:0], e.tol);
    end
  end
  task finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge i_clock);
    error_cnt++;
    $display("watchdog expired");
    finish_test;
  end
  initial begin
    repeat (16) @(posedge i_clock);
    i_sys_rst <= 0;
    rd(`CPMS_IDX_MODE, "setup", `CPMS_SETUP_RST);
    rd(`CPMS_IDX_MASK, "mask", 16'h0000);
    bus(1, 10'h3ff, r[15:0]);
    bus(1, `CPMS_IDX_EXEC_LO, r[15:0]);
    rd(10'h3ff, "unmapped", 16'h0000);
    rd(`CPMS_IDX_EXEC_LO, "exec_lo ro", 16'h0000);
    $display("registers done");
    foreach (codes[i]) begin
      go(codes[i]);
      chk("prog_en", 1, prog);
      chk("setup_err", codes[i] == 8'h03 || codes[i] == 8'h04, serr);
      chk("grant", codes[i] == 8'h01 || codes[i] == 8'h02, grant);
      chk("mem_en", codes[i] == 8'h02, mem);
    end
    bus(1, `CPMS_IDX_MODE, 16'h0200);
    repeat (3) @(posedge i_clock);
    chk("held mode", 0, grant);
    $display("modes done");
    go(8'h05);
    n = 2;
    while (prog === 1'b1 && n < 2000) begin
      @(posedge i_clock);
      n++;
    end
    chk("slice", 16'(5 * 10 * TK), 16'(n), TK);
    $display("slice done");
    bus(1, `CPMS_IDX_SVC_TIME, 16'h0001);
    go(8'h00);
    run_cycle(10 * TK + 2);
    rd(`CPMS_IDX_EXEC_LO, "exec_lo", 16'd10, 1);
    rd(`CPMS_IDX_EXEC_HI, "exec_hi", 16'h0000);
    $display("exec time done");
    // gap from refresh end back to execution: sync spends a servicing window there
    go(8'h01);
    run_cycle(TK);
    chk("sync gap", 16'(2 + TK), 16'(n), TK - 1);
    go(8'h02);
    run_cycle(TK);
    chk("async gap", 16'h0002, 16'(n));
    bus(1, `CPMS_IDX_MIN_CYC, 16'h001e);
    run_cycle(TK);
    rd(`CPMS_IDX_EXEC_LO, "min cycle", 16'h001e);
    $display("cycle modes done");
    go(8'h03);
    bus(1, `CPMS_IDX_STATUS, 16'h0006);
    rd(`CPMS_IDX_STATUS, "status", 16'h0001);
    chk("irq masked", 0, irq);
    bus(1, `CPMS_IDX_MASK, 16'h0001);
    repeat (2) @(posedge i_clock);
    chk("irq", 1, irq);
    bus(1, `CPMS_IDX_STATUS, 16'h0001);
    repeat (2) @(posedge i_clock);
    chk("irq cleared", 0, irq);
    bus(1, `CPMS_IDX_CTRL, 16'h0001);
    @(posedge i_clock);
    chk("setup_err clr", 0, serr);
    $display("interrupt done");
    // the stalled units never end a servicing cycle here, so servicing overruns
    go(8'h02);
    repeat (300) @(posedge i_clock);
    rd(`CPMS_IDX_SVC_CYC, "svc_cycle", 16'd10, 1);
    run <= 0;
    repeat (2) @(posedge i_clock);
    chk("run drop", 0, prog);
    run <= 1;
    go(8'h02);
    stall <= 1;
    n = 0;
    while (halt !== 1'b1 && n < 85000) begin
      @(posedge i_clock);
      n++;
    end
    chk("halt", 1, halt);
    chk("not early", 1, n > 19000 * TK);
    chk("prog stop", 0, prog);
    repeat (20) @(posedge i_clock);
    chk("overrun held", 1, ovr);
    bus(1, `CPMS_IDX_CTRL, 16'h0001);
    @(posedge i_clock);
    chk("overrun clr", 0, ovr);
    $display("overrun done");
    finish_test;
  end
endmodule // cpms_sched_tb
